// ### core/tng_regs.svh
`ifndef TNG_REGS_SVH
`define TNG_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address is four times the index)
`define TNG_IDX_PIN_CTRL 10'h00f
`define TNG_IDX_DIV0_LO 10'h010
`define TNG_IDX_DIV0_HI 10'h011
`define TNG_IDX_DIV1_LO 10'h012
`define TNG_IDX_DIV1_HI 10'h013
`define TNG_IDX_SOUND_CTRL 10'h016
`define TNG_IDX_LOUDNESS 10'h017

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TNG_PIN_INV_BIT 0
`define TNG_PIN_SOUND_BIT 1
`define TNG_CHAN0_LOUDNESS_LSB 0
`define TNG_CHAN1_LOUDNESS_LSB 4
`define TNG_NOISE_BASE_W 6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define TNG_RST_PIN_CTRL 2'h0
`define TNG_RST_DIV 12'h000
`define TNG_RST_SOUND_CTRL 7'h00
`define TNG_RST_LOUDNESS 8'h00
`define TNG_RST_LFSR 15'h0001

////////////////////////////////////////////////////////////////////////////////
// Timing counts
`define TNG_COUNT_TOP 12'hfff
`define TNG_NOISE_RELOAD_HI 6'h3f
`define TNG_PRE_MASK_DIV1 4'h0
`define TNG_PRE_MASK_DIV2 4'h1
`define TNG_PRE_MASK_DIV4 4'h3
`define TNG_PRE_MASK_DIV8 4'h7
`define TNG_PRE_MASK_DIV16 4'hf
`define TNG_LEVEL_MAX 4'hf

`endif

// ### core/tng_pkg.sv
package tng_pkg;

  // Sound control fields, bit 6 down to bit 0
  typedef struct packed {
    logic [2:0] sound_clock_select;
    logic noise_select;
    logic chan1_on;
    logic chan0_on;
    logic sample_player_select;
  } tng_ctrl_s;

  // Bus slave phase
  typedef enum logic [1:0] {
    TNG_BUS_IDLE = 2'b00,
    TNG_BUS_WRITE = 2'b01,
    TNG_BUS_RD_WAIT = 2'b10,
    TNG_BUS_RD_DONE = 2'b11
  } tng_bus_e;

endpackage : tng_pkg

// ### core/tng_top.sv
`timescale 1ns/1ps
`include "tng_regs.svh"

// Behaviour
// - Each channel has a 12-bit up counter auto-reloading its divider on overflow.
// - Channel 0 tone toggles per overflow: sound clock/(4096-divider)/2.
// - Channel 1 tone gives sound clock/(4096-divider)/2.
// - Control bit 0 selects sample player (1) or tone/noise generator (0).
// - Control bit 1 enables channel 0 tone in tone/noise function.
// - Control bit 2 enables channel 1, tone or noise.
// - Control bit 3 makes channel 1 noise (1) or tone (0).
// - Noise base frequency comes from low six bits of channel 1 low divider.
// - Writing 1 to channel 1 enable starts noise in noise mode.
// - Channel 0 alone with all volume bits set gives maximum level.
// - Port B bit 0 carries inverted sound when enabled and set as output.
// - Clock select: 000 /2, X01 /4, X10 /8, X11 /16, 100 /1.
module tng_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] pb_dir,
  input wire logic [1:0] pb_gpio,
  output logic [1:0] pb_out,
  output logic [1:0] pb_oe,
  output logic [3:0] sound_level
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [9:0] reg_index(input logic [31:0] addr);
    reg_index = addr[11:2];
  endfunction : reg_index

  function automatic logic [11:0] count_step(input logic [11:0] cnt, input logic [11:0] reload);
    if (cnt == `TNG_COUNT_TOP) begin
      count_step = reload;
    end else begin
      count_step = cnt + 12'h001;
    end
  endfunction : count_step

  function automatic logic [3:0] pre_mask(input logic [2:0] sel);
    unique case (sel)
      3'b000: pre_mask = `TNG_PRE_MASK_DIV2;
      3'b001, 3'b101: pre_mask = `TNG_PRE_MASK_DIV4;
      3'b010, 3'b110: pre_mask = `TNG_PRE_MASK_DIV8;
      3'b011, 3'b111: pre_mask = `TNG_PRE_MASK_DIV16;
      3'b100: pre_mask = `TNG_PRE_MASK_DIV1;
    endcase
  endfunction : pre_mask

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  tng_pkg::tng_bus_e bus_q;
  logic [9:0] addr_q;
  logic [31:0] hrdata_q;
  logic [7:0] rd_byte;
  logic addr_ok;
  logic wr_en;

  tng_pkg::tng_ctrl_s ctrl_q;
  logic [7:0] loud_q;
  logic [1:0] pin_q;
  logic [11:0] div0_q;
  logic [11:0] div1_q;

  logic [3:0] pre_q;
  logic tick;
  logic en0;
  logic en1;
  logic [11:0] reload1;
  logic [11:0] cnt0_q;
  logic [11:0] cnt1_q;
  logic ovf0;
  logic ovf1;
  logic tone0_q;
  logic tone1_q;
  logic [14:0] lfsr_q;
  logic ch1_bit;

  logic [3:0] amp0;
  logic [3:0] amp1;
  logic [4:0] amp_sum;
  logic [3:0] level_q;
  logic [3:0] pwm_q;
  logic sound_q;
  logic [1:0] pb_out_q;
  logic [1:0] pb_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave

  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= tng_pkg::TNG_BUS_IDLE;
    end else if (clk_en) begin
      unique case (bus_q)
        tng_pkg::TNG_BUS_RD_WAIT: begin
          bus_q <= tng_pkg::TNG_BUS_RD_DONE;
        end
        tng_pkg::TNG_BUS_IDLE, tng_pkg::TNG_BUS_WRITE, tng_pkg::TNG_BUS_RD_DONE: begin
          if (addr_ok) begin
            bus_q <= hwrite ? tng_pkg::TNG_BUS_WRITE : tng_pkg::TNG_BUS_RD_WAIT;
          end else begin
            bus_q <= tng_pkg::TNG_BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 10'h000;
    end else if (clk_en && addr_ok && (bus_q != tng_pkg::TNG_BUS_RD_WAIT)) begin
      addr_q <= reg_index(haddr);
    end
  end

  assign wr_en = clk_en && (bus_q == tng_pkg::TNG_BUS_WRITE);

  always_comb begin
    rd_byte = 8'h00;
    unique case (addr_q)
      `TNG_IDX_PIN_CTRL: rd_byte = {6'h00, pin_q};
      `TNG_IDX_DIV0_LO: rd_byte = div0_q[7:0];
      `TNG_IDX_DIV0_HI: rd_byte = {4'h0, div0_q[11:8]};
      `TNG_IDX_DIV1_LO: rd_byte = div1_q[7:0];
      `TNG_IDX_DIV1_HI: rd_byte = {4'h0, div1_q[11:8]};
      `TNG_IDX_SOUND_CTRL: rd_byte = {1'b0, ctrl_q};
      `TNG_IDX_LOUDNESS: rd_byte = loud_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (clk_en && (bus_q == tng_pkg::TNG_BUS_RD_WAIT)) begin
      hrdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign hreadyout = (bus_q != tng_pkg::TNG_BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TNG_RST_SOUND_CTRL;
    end else if (wr_en && (addr_q == `TNG_IDX_SOUND_CTRL)) begin
      ctrl_q <= hwdata[6:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loud_q <= `TNG_RST_LOUDNESS;
    end else if (wr_en && (addr_q == `TNG_IDX_LOUDNESS)) begin
      loud_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= `TNG_RST_PIN_CTRL;
    end else if (wr_en && (addr_q == `TNG_IDX_PIN_CTRL)) begin
      pin_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div0_q <= `TNG_RST_DIV;
    end else if (wr_en && (addr_q == `TNG_IDX_DIV0_LO)) begin
      div0_q[7:0] <= hwdata[7:0];
    end else if (wr_en && (addr_q == `TNG_IDX_DIV0_HI)) begin
      div0_q[11:8] <= hwdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div1_q <= `TNG_RST_DIV;
    end else if (wr_en && (addr_q == `TNG_IDX_DIV1_LO)) begin
      div1_q[7:0] <= hwdata[7:0];
    end else if (wr_en && (addr_q == `TNG_IDX_DIV1_HI)) begin
      div1_q[11:8] <= hwdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sound clock prescaler

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 4'h0;
    end else if (clk_en) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // One tick per sound clock period
  assign tick = clk_en && ((pre_q & pre_mask(ctrl_q.sound_clock_select)) == pre_mask(ctrl_q.sound_clock_select));

  //////////////////////////////////////////////////////////////////////////////
  // Channel counters

  assign en0 = !ctrl_q.sample_player_select && ctrl_q.chan0_on;
  assign en1 = !ctrl_q.sample_player_select && ctrl_q.chan1_on;
  assign reload1 = ctrl_q.noise_select ? {`TNG_NOISE_RELOAD_HI, div1_q[`TNG_NOISE_BASE_W-1:0]} : div1_q;
  assign ovf0 = tick && (cnt0_q == `TNG_COUNT_TOP);
  assign ovf1 = tick && (cnt1_q == `TNG_COUNT_TOP);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt0_q <= `TNG_RST_DIV;
    end else if (clk_en && !en0) begin
      cnt0_q <= div0_q;
    end else if (tick) begin
      cnt0_q <= count_step(cnt0_q, div0_q);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt1_q <= `TNG_RST_DIV;
    end else if (clk_en && !en1) begin
      cnt1_q <= reload1;
    end else if (tick) begin
      cnt1_q <= count_step(cnt1_q, reload1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone0_q <= 1'b0;
    end else if (clk_en && !en0) begin
      tone0_q <= 1'b0;
    end else if (ovf0) begin
      tone0_q <= !tone0_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone1_q <= 1'b0;
    end else if (clk_en && (!en1 || ctrl_q.noise_select)) begin
      tone1_q <= 1'b0;
    end else if (ovf1) begin
      tone1_q <= !tone1_q;
    end
  end

  // Reseeded while off, so each enable starts the same sequence
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= `TNG_RST_LFSR;
    end else if (clk_en && !en1) begin
      lfsr_q <= `TNG_RST_LFSR;
    end else if (ovf1 && ctrl_q.noise_select) begin
      lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
    end
  end

  assign ch1_bit = ctrl_q.noise_select ? lfsr_q[14] : tone1_q;

  //////////////////////////////////////////////////////////////////////////////
  // Mixer and level modulator

  assign amp0 = (en0 && tone0_q) ? loud_q[`TNG_CHAN0_LOUDNESS_LSB +: 4] : 4'h0;
  assign amp1 = (en1 && ch1_bit) ? loud_q[`TNG_CHAN1_LOUDNESS_LSB +: 4] : 4'h0;
  assign amp_sum = {1'b0, amp0} + {1'b0, amp1};

  // Saturate: channel 0 alone at full loudness already hits the top
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 4'h0;
    end else if (clk_en) begin
      level_q <= amp_sum[4] ? `TNG_LEVEL_MAX : amp_sum[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q <= 4'h0;
    end else if (clk_en) begin
      pwm_q <= pwm_q + 4'h1;
    end
  end

  // High for level sixteenths of each pulse frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sound_q <= 1'b0;
    end else if (clk_en) begin
      sound_q <= (pwm_q < level_q);
    end
  end

  assign sound_level = level_q;

  //////////////////////////////////////////////////////////////////////////////
  // Port B pins

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_out_q <= 2'b00;
      pb_oe_q <= 2'b00;
    end else if (clk_en) begin
      pb_oe_q <= pb_dir;
      pb_out_q[1] <= pin_q[`TNG_PIN_SOUND_BIT] ? sound_q : pb_gpio[1];
      pb_out_q[0] <= pin_q[`TNG_PIN_INV_BIT] ? !sound_q : pb_gpio[0];
    end
  end

  assign pb_out = pb_out_q;
  assign pb_oe = pb_oe_q;

endmodule : tng_top

// ### tb/tng_assertions.sv
`timescale 1ns/1ps
module tng_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] pb_dir,
  input wire logic [1:0] pb_oe,
  input wire logic [3:0] sound_level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = hsel && hready && htrans[1] && clk_en;
  logic take_rd;
  assign take_rd = take && !hwrite;
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  chk_write_fast: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  chk_wait_cause: assert property ($fell(hreadyout) |-> $past(take_rd)) else $error("stray wait");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper data set");
  chk_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout)) else $error("read data moved");
  chk_oe_follow: assert property (clk_en |=> pb_oe == $past(pb_dir)) else $error("pin enable wrong");
  chk_freeze_all: assert property (!clk_en |=> $stable(sound_level) && $stable(pb_oe))
    else $error("moved while frozen");
endmodule : tng_chk

bind tng_top tng_chk u_chk (.core_clk, .rst_n, .clk_en, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .pb_dir, .pb_oe, .sound_level);

// ### tb/tng_speaker.sv
`timescale 1ns/1ps
module tng_speaker (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [1:0] pb_out,
  input wire logic [1:0] pb_oe,
  output int hi_cnt,
  output int same_cnt
);
  // Listens only while both pins drive
  always @(posedge core_clk) begin
    if (clr) begin
      hi_cnt <= 0;
      same_cnt <= 0;
    end else if (pb_oe == 2'b11) begin
      hi_cnt <= hi_cnt + int'(pb_out[1]);
      same_cnt <= same_cnt + int'(pb_out[1] == pb_out[0]);
    end
  end
endmodule : tng_speaker

// ### tb/tb_tone_noise_sound_generator.sv
`timescale 1ns/1ps
`include "tng_regs.svh"
module tb_tone_noise_sound_generator;
  logic core_clk = 0, rst_n = 0, clk_en = 1, hsel = 0, hwrite = 0, clr = 1, rd_dp = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, pb_dir = 0, pb_gpio = 0, pb_out, pb_oe;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp;
  logic [3:0] sound_level;
  logic [4:0] divs [8] = '{2, 4, 8, 16, 1, 4, 8, 16};
  logic [31:0] exp_q [$];
  int err_count = 0, checked = 0, hi_cnt, same_cnt, n, mx;
  integer seed = 32'ha07030e6;
  tng_top uut (.core_clk, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pb_dir, .pb_gpio, .pb_out, .pb_oe, .sound_level);
  tng_speaker spk (.core_clk, .clr, .pb_out, .pb_oe, .hi_cnt, .same_cnt);
  initial forever #10 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic near(input int got, input int e);
    check((got >= e - 1 && got <= e + 1) ? e : got, e);
  endtask : near
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'b00};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic rd(input logic [9:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, idx, 32'h0);
  endtask : rd
  task automatic meas(input int w);
    logic prev;
    n = 0;
    mx = 0;
    repeat (3) @(negedge core_clk);
    prev = (sound_level != 0);
    repeat (w) begin
      @(negedge core_clk);
      if (sound_level != 0 && !prev) n++;
      prev = (sound_level != 0);
      if (sound_level > mx) mx = sound_level;
    end
    @(posedge core_clk);
  endtask : meas
  task automatic close_out;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    if (rd_dp && hreadyout === 1'b1) check(hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1) rd_dp = hsel && htrans[1] && !hwrite;
  end
  initial begin
    #1000000;
    err_count++;
    close_out();
  end
  initial begin
    int v;
    v = ($random(seed) & 255) | 17;
    repeat (3) @(posedge core_clk);
    pb_dir <= $random(seed);
    rst_n <= 1;
    @(posedge core_clk);
    rd(`TNG_IDX_SOUND_CTRL, 0);
    rd(`TNG_IDX_LOUDNESS, 0);
    bus(1, `TNG_IDX_PIN_CTRL, 32'hff);
    rd(`TNG_IDX_PIN_CTRL, 3);
    bus(1, 10'h000, 32'h5a);
    rd(10'h000, 0);
    bus(1, `TNG_IDX_LOUDNESS, v);
    rd(`TNG_IDX_LOUDNESS, v);
    bus(1, `TNG_IDX_DIV0_LO, 32'hfe);
    bus(1, `TNG_IDX_DIV0_HI, 32'hf);
    for (int s = 0; s < 8; s++) begin
      bus(1, `TNG_IDX_SOUND_CTRL, s << 4 | 2);
      meas(1600);
      near(n, 400 / divs[s]);
    end
    check(mx, v & 15);
    clk_en <= 0;
    repeat (5) @(posedge core_clk);
    clk_en <= 1;
    bus(1, `TNG_IDX_SOUND_CTRL, 32'h42);
    meas(1600);
    near(n, 400);
    bus(1, `TNG_IDX_LOUDNESS, 32'hff);
    meas(100);
    check(mx, 15);
    pb_dir <= 2'b11;
    clr <= 0;
    repeat (400) @(posedge core_clk);
    check(same_cnt, 0);
    check(hi_cnt > 0, 1);
    bus(1, `TNG_IDX_SOUND_CTRL, 32'h40);
    meas(200);
    check(n, 0);
    bus(1, `TNG_IDX_SOUND_CTRL, 32'h47);
    meas(200);
    check(n, 0);
    bus(1, `TNG_IDX_LOUDNESS, v);
    bus(1, `TNG_IDX_DIV1_LO, 32'hfc);
    bus(1, `TNG_IDX_DIV1_HI, 32'hf);
    bus(1, `TNG_IDX_SOUND_CTRL, 32'h44);
    meas(1600);
    near(n, 200);
    check(mx, v >> 4);
    // Upper divider bits must not slow the noise
    bus(1, `TNG_IDX_DIV1_HI, 32'h0);
    bus(1, `TNG_IDX_SOUND_CTRL, 32'h48);
    meas(200);
    check(n, 0);
    bus(1, `TNG_IDX_SOUND_CTRL, 32'h4c);
    meas(1600);
    check(n > 10 && n < 190, 1);
    check(mx, v >> 4);
    bus(1, `TNG_IDX_PIN_CTRL, 32'h0);
    repeat (4) begin
      pb_gpio <= $random(seed);
      repeat (3) @(posedge core_clk);
      check(pb_out, pb_gpio);
    end
    close_out();
  end
endmodule : tb_tone_noise_sound_generator
